// [logic/tct_top.sv]
// Test access logic for the translation buffer and the on-chip cache
// What this block does
// - Translation buffer has four ways of eight entries; writes target any way.
// - Entry holds 20-bit linear tag, valid, three attributes, 20-bit physical page.
// - Command bit 0 picks operation: 0 writes an entry, 1 looks up.
// - Lookup searches with command bits 31-12; only a single match updates the page, attribute, LRU and way fields.
// - Entry write allocates the command's linear address, storing the data's page.
// - Command bit 11 is valid: forced 1 on lookup, stored on write.
// - Attribute pairs: dirty 10-9, user 8-7, read/write 6-5, bit with complement.
// - Pair 00 never matches, 01 stored 0, 10 stored 1, 11 either.
// - Data bits 31-12 return the matched page, or supply it on write.
// - Data bit 11 is page cache disable, bit 10 page write-through.
// - Data bits 9-7 return set replacement state from before a lookup that hits; ignored on write.
// - After lookup data bit 4 reads 1 on hit, 0 on miss.
// - On write data bit 4 set uses way field, clear uses pseudo-LRU victim.
// - Data bits 3-2 report hit way, or pick way on write with bit 4.
// - Cache has two ways of 128 lines, each reachable by test operations.
// - Cache line holds 23-bit tag, 32-bit data and four byte valid bits.
// - Cache test read returns data, valid bits and LRU bit to registers.
// - Cache test write stores data register into the chosen line and way.
// - Control bits 1-0: 00 idle, 01 write, 10 read, 11 flush all.
// - Control bits 10-4 pick the line, bit 2 picks the way.
// - Tag register: tag 31-9, read-only LRU bit 7, valid bits 6-3.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module tct_top #(
  parameter int CACHE_LINES = 128,
  parameter int TLB_WAYS_P = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // Geometry is fixed by the register fields
  if (CACHE_LINES != tct_pkg::C_LINES || TLB_WAYS_P != tct_pkg::TLB_WAYS) begin : g_bad
    $error("tct_top geometry parameters must keep their documented values");
  end

  logic [31:0] cmd_r;
  logic [31:0] dat_r;
  logic [31:0] cdat_r;
  logic [31:0] ctag_r;
  logic [31:0] cctl_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic tlb_go_r;
  logic cache_go_r;

  // Translation buffer storage, ways by sets
  logic [19:0] t_tag_r [4][8];
  logic [19:0] t_pa_r [4][8];
  logic t_val_r [4][8];
  logic [2:0] t_attr_r [4][8];
  logic [1:0] t_pg_r [4][8];
  logic [2:0] t_lru_r [8];

  // Cache storage, ways by lines
  logic [22:0] c_tag_r [2][128];
  logic [31:0] c_dat_r [2][128];
  logic [3:0] c_val_r [2][128];
  logic c_lru_r [128];

  // Bus access decode
  logic req;
  logic wr;
  logic [31:0] bmask;
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Merges the selected byte lanes into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Lookup inputs taken from the command register
  logic [2:0] set_idx;
  logic [19:0] lin;
  logic [1:0] pd;
  logic [1:0] pu;
  logic [1:0] pw;
  assign set_idx = cmd_r[tct_pkg::CMD_LIN_LO +: 3];
  assign lin = cmd_r[tct_pkg::CMD_LIN_LO +: 20];
  assign pd = cmd_r[tct_pkg::CMD_DIRTY +: 2];
  assign pu = cmd_r[tct_pkg::CMD_USER +: 2];
  assign pw = cmd_r[tct_pkg::CMD_RW +: 2];

  // Pair test: upper bit passes a stored 1, lower bit a stored 0
  function automatic logic pair_ok(input logic [1:0] p, input logic s);
    pair_ok = s ? p[1] : p[0];
  endfunction

  // Per-way match on tag, valid and the three attributes
  logic [3:0] hit_vec;
  for (genvar w = 0; w < 4; w++) begin : g_match
    assign hit_vec[w] = t_val_r[w][set_idx] && (t_tag_r[w][set_idx] == lin) &&
                        pair_ok(pd, t_attr_r[w][set_idx][2]) &&
                        pair_ok(pu, t_attr_r[w][set_idx][1]) &&
                        pair_ok(pw, t_attr_r[w][set_idx][0]);
  end

  // Exactly one way must match for a hit
  logic single_hit;
  logic [1:0] hit_way;
  assign single_hit = (hit_vec != 4'h0) && ((hit_vec & (hit_vec - 4'h1)) == 4'h0);
  always_comb begin
    hit_way = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (hit_vec[i]) begin
        hit_way = 2'(i);
      end
    end
  end

  // Pseudo-LRU tree: bit 0 picks half, bits 1 and 2 pick within it
  function automatic logic [1:0] victim(input logic [2:0] t);
    if (!t[0]) begin
      victim = t[1] ? 2'h1 : 2'h0;
    end else begin
      victim = t[2] ? 2'h3 : 2'h2;
    end
  endfunction

  function automatic logic [2:0] touch(input logic [2:0] t, input logic [1:0] w);
    logic [2:0] n;
    n = t;
    n[0] = !w[1];
    if (!w[1]) begin
      n[1] = !w[0];
    end else begin
      n[2] = !w[0];
    end
    touch = n;
  endfunction

  // Way chosen for an entry write
  logic [1:0] wr_way;
  logic is_lookup;
  assign wr_way = dat_r[tct_pkg::DAT_HIT] ? dat_r[tct_pkg::DAT_WAY_LO +: 2]
                                          : victim(t_lru_r[set_idx]);
  assign is_lookup = cmd_r[tct_pkg::CMD_OP];

  // Cache operation selection
  logic [6:0] c_line;
  logic c_way;
  logic [1:0] c_op;
  assign c_line = cctl_r[tct_pkg::CCTL_LINE_LO +: 7];
  assign c_way = cctl_r[tct_pkg::CCTL_WAY];
  assign c_op = cctl_r[1:0];

  // Bus handshake: one wait state, ack drops the cycle after
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data mux, unmapped offsets read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdat_r <= tct_pkg::REG_RESET;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        tct_pkg::OFF_TLB_CMD: rdat_r <= cmd_r & tct_pkg::CMD_MASK;
        tct_pkg::OFF_TLB_DAT: rdat_r <= dat_r & tct_pkg::DAT_MASK;
        tct_pkg::OFF_C_DATA: rdat_r <= cdat_r;
        tct_pkg::OFF_C_TAG: rdat_r <= ctag_r & tct_pkg::CTAG_MASK;
        tct_pkg::OFF_C_CTL: rdat_r <= cctl_r & tct_pkg::CCTL_MASK;
        default: rdat_r <= tct_pkg::REG_RESET;
      endcase
    end
  end

  // Operation triggers: a write to a command register starts it next edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tlb_go_r <= 1'b0;
      cache_go_r <= 1'b0;
    end else begin
      tlb_go_r <= wr && (wb_adr_i == tct_pkg::OFF_TLB_CMD);
      cache_go_r <= wr && (wb_adr_i == tct_pkg::OFF_C_CTL);
    end
  end

  // Command register: bus writes, lookup result fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= tct_pkg::REG_RESET;
    end else if (wr && (wb_adr_i == tct_pkg::OFF_TLB_CMD)) begin
      cmd_r <= merge(cmd_r, wb_dat_i, bmask);
    end else if (tlb_go_r && is_lookup) begin
      cmd_r[tct_pkg::CMD_VALID] <= 1'b1;
      if (single_hit) begin
        cmd_r[tct_pkg::CMD_DIRTY +: 2] <= t_attr_r[hit_way][set_idx][2] ? 2'h2 : 2'h1;
        cmd_r[tct_pkg::CMD_USER +: 2] <= t_attr_r[hit_way][set_idx][1] ? 2'h2 : 2'h1;
        cmd_r[tct_pkg::CMD_RW +: 2] <= t_attr_r[hit_way][set_idx][0] ? 2'h2 : 2'h1;
      end
    end
  end

  // Data register: bus writes, lookup results
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dat_r <= tct_pkg::REG_RESET;
    end else if (wr && (wb_adr_i == tct_pkg::OFF_TLB_DAT)) begin
      dat_r <= merge(dat_r, wb_dat_i, bmask);
    end else if (tlb_go_r && is_lookup) begin
      dat_r[tct_pkg::DAT_HIT] <= single_hit;
      if (single_hit) begin
        dat_r[tct_pkg::DAT_PA_LO +: 20] <= t_pa_r[hit_way][set_idx];
        dat_r[tct_pkg::DAT_PCD] <= t_pg_r[hit_way][set_idx][1];
        dat_r[tct_pkg::DAT_PWT] <= t_pg_r[hit_way][set_idx][0];
        dat_r[tct_pkg::DAT_LRU_LO +: 3] <= t_lru_r[set_idx];
        dat_r[tct_pkg::DAT_WAY_LO +: 2] <= hit_way;
      end
    end
  end

  // Translation valid bits and replacement state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < 4; w++) begin
        for (int s = 0; s < 8; s++) begin
          t_val_r[w][s] <= 1'b0;
        end
      end
      for (int s = 0; s < 8; s++) begin
        t_lru_r[s] <= tct_pkg::LRU_RESET;
      end
    end else if (tlb_go_r) begin
      if (!is_lookup) begin
        t_val_r[wr_way][set_idx] <= cmd_r[tct_pkg::CMD_VALID];
        t_lru_r[set_idx] <= touch(t_lru_r[set_idx], wr_way);
      end else if (single_hit) begin
        t_lru_r[set_idx] <= touch(t_lru_r[set_idx], hit_way);
      end
    end
  end

  // Translation entry contents on a write; 00 and 11 pairs store the upper bit
  always_ff @(posedge clock) begin
    if (tlb_go_r && !is_lookup) begin
      t_tag_r[wr_way][set_idx] <= lin;
      t_attr_r[wr_way][set_idx] <= {pd[1], pu[1], pw[1]};
      t_pa_r[wr_way][set_idx] <= dat_r[tct_pkg::DAT_PA_LO +: 20];
      t_pg_r[wr_way][set_idx] <= {dat_r[tct_pkg::DAT_PCD], dat_r[tct_pkg::DAT_PWT]};
    end
  end

  // Cache data register: bus writes, test read result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cdat_r <= tct_pkg::REG_RESET;
    end else if (wr && (wb_adr_i == tct_pkg::OFF_C_DATA)) begin
      cdat_r <= merge(cdat_r, wb_dat_i, bmask);
    end else if (cache_go_r && (c_op == tct_pkg::COP_READ)) begin
      cdat_r <= c_dat_r[c_way][c_line];
    end
  end

  // Cache tag register: LRU bit is read only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctag_r <= tct_pkg::REG_RESET;
    end else if (wr && (wb_adr_i == tct_pkg::OFF_C_TAG)) begin
      ctag_r <= merge(ctag_r, wb_dat_i, bmask & ~(32'h1 << tct_pkg::CTAG_LRU));
    end else if (cache_go_r && (c_op == tct_pkg::COP_READ)) begin
      ctag_r[tct_pkg::CTAG_LO +: 23] <= c_tag_r[c_way][c_line];
      ctag_r[tct_pkg::CTAG_LRU] <= c_lru_r[c_line];
      ctag_r[tct_pkg::CTAG_VAL_LO +: 4] <= c_val_r[c_way][c_line];
    end
  end

  // Cache control register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cctl_r <= tct_pkg::REG_RESET;
    end else if (wr && (wb_adr_i == tct_pkg::OFF_C_CTL)) begin
      cctl_r <= merge(cctl_r, wb_dat_i, bmask);
    end
  end

  // Cache valid bits and LRU: write loads, flush clears all valid bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < 128; l++) begin
        c_val_r[0][l] <= 4'h0;
        c_val_r[1][l] <= 4'h0;
        c_lru_r[l] <= 1'b0;
      end
    end else if (cache_go_r) begin
      unique case (c_op)
        tct_pkg::COP_WRITE: begin
          c_val_r[c_way][c_line] <= ctag_r[tct_pkg::CTAG_VAL_LO +: 4];
          c_lru_r[c_line] <= !c_way;
        end
        tct_pkg::COP_FLUSH: begin
          for (int l = 0; l < 128; l++) begin
            c_val_r[0][l] <= 4'h0;
            c_val_r[1][l] <= 4'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Cache tag and data contents on a test write
  always_ff @(posedge clock) begin
    if (cache_go_r && (c_op == tct_pkg::COP_WRITE)) begin
      c_tag_r[c_way][c_line] <= ctag_r[tct_pkg::CTAG_LO +: 23];
      c_dat_r[c_way][c_line] <= cdat_r;
    end
  end

endmodule
`default_nettype wire

// [logic/tct_pkg.sv]
// Constants for the translation buffer and cache test access block
package tct_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_TLB_CMD = 8'h00;
  localparam logic [7:0] OFF_TLB_DAT = 8'h04;
  localparam logic [7:0] OFF_C_DATA = 8'h08;
  localparam logic [7:0] OFF_C_TAG = 8'h0C;
  localparam logic [7:0] OFF_C_CTL = 8'h10;
  // Geometry
  localparam int TLB_WAYS = 4;
  localparam int TLB_SETS = 8;
  localparam int C_WAYS = 2;
  localparam int C_LINES = 128;
  // Command register fields
  localparam int CMD_LIN_LO = 12;
  localparam int CMD_VALID = 11;
  localparam int CMD_DIRTY = 9;
  localparam int CMD_USER = 7;
  localparam int CMD_RW = 5;
  localparam int CMD_OP = 0;
  localparam logic [31:0] CMD_MASK = 32'hFFFFFFE1;
  // Data register fields
  localparam int DAT_PA_LO = 12;
  localparam int DAT_PCD = 11;
  localparam int DAT_PWT = 10;
  localparam int DAT_LRU_LO = 7;
  localparam int DAT_HIT = 4;
  localparam int DAT_WAY_LO = 2;
  localparam logic [31:0] DAT_MASK = 32'hFFFFFF9C;
  // Cache tag register fields
  localparam int CTAG_LO = 9;
  localparam int CTAG_LRU = 7;
  localparam int CTAG_VAL_LO = 3;
  localparam logic [31:0] CTAG_MASK = 32'hFFFFFEF8;
  // Cache control register fields
  localparam int CCTL_LINE_LO = 4;
  localparam int CCTL_WAY = 2;
  localparam logic [31:0] CCTL_MASK = 32'h000007F7;
  localparam logic [1:0] COP_NONE = 2'h0;
  localparam logic [1:0] COP_WRITE = 2'h1;
  localparam logic [1:0] COP_READ = 2'h2;
  localparam logic [1:0] COP_FLUSH = 2'h3;
  // Reset values
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [2:0] LRU_RESET = 3'h0;
endpackage

// [sim/tct_checker.sv]
// Bus and register layout assertions for the test access block
`timescale 1ns/10ps
`default_nettype none
module tct_checker #(
  parameter int CACHE_LINES = 128,
  parameter int TLB_WAYS_P = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rd_ack;
  logic mapped;
  // Read answer and address decode
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign mapped = wb_adr_i inside {tct_pkg::OFF_TLB_CMD, tct_pkg::OFF_TLB_DAT,
    tct_pkg::OFF_C_DATA, tct_pkg::OFF_C_TAG, tct_pkg::OFF_C_CTL};
  // Steps of one bus transfer
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_pulse: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse after request");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_only_read: assert property ($changed(wb_dat_o) |-> rd_ack)
    else $error("read data changed outside a read");
  a_write_keeps_dat: assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
    else $error("write disturbed read data");
  a_unmapped_zero: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_cmd_reserved: assert property (rd_ack && wb_adr_i == tct_pkg::OFF_TLB_CMD
    |-> (wb_dat_o & ~tct_pkg::CMD_MASK) == 32'h0) else $error("command reserved bits set");
  a_dat_reserved: assert property (rd_ack && wb_adr_i == tct_pkg::OFF_TLB_DAT
    |-> (wb_dat_o & ~tct_pkg::DAT_MASK) == 32'h0) else $error("data reserved bits set");
  a_tag_reserved: assert property (rd_ack && wb_adr_i == tct_pkg::OFF_C_TAG
    |-> (wb_dat_o & ~tct_pkg::CTAG_MASK) == 32'h0) else $error("tag reserved bits set");
  a_ctl_reserved: assert property (rd_ack && wb_adr_i == tct_pkg::OFF_C_CTL
    |-> (wb_dat_o & ~tct_pkg::CCTL_MASK) == 32'h0) else $error("control reserved bits set");
endmodule
bind tct_top tct_checker #(.CACHE_LINES(CACHE_LINES), .TLB_WAYS_P(TLB_WAYS_P)) u_chk (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o));
`default_nettype wire

// [sim/tct_tb.sv]
// Self-checking bench for the test access block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tct_row_t;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  // Bus steps: writes give the value, reads the expected word
  // Valid bits go into the tag register before the cache write
  tct_row_t rows [40] = '{
    '{1'h1, 8'h04, 4'hF, 32'hABCDE818}, '{1'h1, 8'h00, 4'hF, 32'h12345CC0},
    '{1'h1, 8'h04, 4'hF, 32'h00000000}, '{1'h1, 8'h00, 4'hF, 32'h123457E1},
    '{1'h0, 8'h00, 4'hF, 32'h12345CC1}, '{1'h0, 8'h04, 4'hF, 32'hABCDEA18},
    '{1'h1, 8'h00, 4'hF, 32'h12345001}, '{1'h0, 8'h00, 4'hF, 32'h12345801},
    '{1'h0, 8'h04, 4'hF, 32'hABCDEA08}, '{1'h1, 8'h00, 4'hF, 32'h123453E1},
    '{1'h0, 8'h00, 4'hF, 32'h12345BE1}, '{1'h1, 8'h04, 4'hF, 32'h1111140C},
    '{1'h1, 8'h00, 4'hF, 32'h00005AA0}, '{1'h1, 8'h00, 4'hF, 32'h000057E1},
    '{1'h0, 8'h00, 4'hF, 32'h00005AA1}, '{1'h0, 8'h04, 4'hF, 32'h11111790},
    '{1'h1, 8'h04, 4'hF, 32'h00000018}, '{1'h1, 8'h00, 4'hF, 32'h123454C0},
    '{1'h1, 8'h00, 4'hF, 32'h123457E1}, '{1'h0, 8'h00, 4'hF, 32'h12345FE1},
    '{1'h0, 8'h04, 4'hF, 32'h00000008}, '{1'h1, 8'h08, 4'hF, 32'hDEADBEEF},
    '{1'h1, 8'h0C, 4'hF, 32'hCAFE00F8}, '{1'h0, 8'h0C, 4'hF, 32'hCAFE0078},
    '{1'h1, 8'h10, 4'hF, 32'h00000551}, '{1'h1, 8'h08, 4'hF, 32'h00000000},
    '{1'h1, 8'h0C, 4'hF, 32'h00000000}, '{1'h1, 8'h10, 4'hF, 32'h00000552},
    '{1'h0, 8'h08, 4'hF, 32'hDEADBEEF}, '{1'h0, 8'h0C, 4'hF, 32'hCAFE00F8},
    '{1'h0, 8'h10, 4'hF, 32'h00000552}, '{1'h1, 8'h10, 4'hF, 32'h00000003},
    '{1'h1, 8'h10, 4'hF, 32'h00000552}, '{1'h0, 8'h0C, 4'hF, 32'hCAFE0080},
    '{1'h1, 8'h10, 4'hF, 32'h0000FFF8}, '{1'h0, 8'h10, 4'hF, 32'h000007F0},
    '{1'h1, 8'h14, 4'hF, 32'hFFFFFFFF}, '{1'h0, 8'h14, 4'hF, 32'h00000000},
    '{1'h1, 8'h08, 4'h1, 32'h12345678}, '{1'h0, 8'h08, 4'hF, 32'hDEADBE78}};
  tct_top dut (
    .clock(clock),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
  );
  // Clock at 100 MHz
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic cycle, entered just after a rising edge; ack and data taken at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clock);
  endtask
  // Counts and verdict
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat, rd);
      if (!rows[i].we) chk(rd, rows[i].dat);
      // Rows above also cover
      // Rows above also cover
    end
    $display("Table test done");
    // Second reset mid-run: registers clear and entries are forgotten
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    for (int a = 0; a < 5; a++) begin
      bus(1'h0, 8'(a * 4), 4'hF, 32'h0, rd);
      chk(rd, 32'h00000000);
    end
    bus(1'h1, 8'h00, 4'hF, 32'h123457E1, rd);
    bus(1'h0, 8'h04, 4'hF, 32'h0, rd);
    chk(rd, 32'h00000000);
    bus(1'h0, 8'h00, 4'hF, 32'h0, rd);
    chk(rd, 32'h12345FE1);
    $display("Reset test done");
    close_out();
  end
endmodule
`default_nettype wire
